// *** otfs_map.svh ***
`ifndef OTFS_MAP_SVH
`define OTFS_MAP_SVH

// ============================================================
// Selection codes
`define OTFS_SEL_NONE          6'h00
`define OTFS_SEL_RUN           6'h01
`define OTFS_SEL_FWD           6'h02
`define OTFS_SEL_REV           6'h03
`define OTFS_SEL_JOG           6'h04
`define OTFS_SEL_FAULT         6'h05
`define OTFS_SEL_LEVEL_ONE     6'h06
`define OTFS_SEL_LEVEL_TWO     6'h07
`define OTFS_SEL_REACHED       6'h08
`define OTFS_SEL_ZERO_SPEED    6'h09
`define OTFS_SEL_UPPER         6'h0A
`define OTFS_SEL_LOWER         6'h0B
`define OTFS_SEL_READY         6'h0C
`define OTFS_SEL_PREEXC        6'h0D
`define OTFS_SEL_OVERLOAD      6'h0E
`define OTFS_SEL_UNDERLOAD     6'h0F
`define OTFS_SEL_STAGE_DONE    6'h10
`define OTFS_SEL_CYCLE_DONE    6'h11
`define OTFS_SEL_VBIT_MODBUS   6'h17
`define OTFS_SEL_VBIT_FIELDBUS 6'h18
`define OTFS_SEL_VBIT_ETHERNET 6'h19
`define OTFS_SEL_DC_BUS        6'h1A
`define OTFS_SEL_INDEX         6'h1B
`define OTFS_SEL_SUPERPOS      6'h1C
`define OTFS_SEL_TORQUE_OFF    6'h1D
`define OTFS_SEL_POS_DONE      6'h1E
`define OTFS_SEL_ZERO_DONE     6'h1F
`define OTFS_SEL_DIV_DONE      6'h20
`define OTFS_SEL_LIMIT         6'h21
`define OTFS_SEL_VBIT_INDETH   6'h22
`define OTFS_SEL_MODE_SW_DONE  6'h24
`define OTFS_SEL_USER_FIRST    6'h29
`define OTFS_SEL_USER_LAST     6'h2F

// ============================================================
// Settings and reset values
`define OTFS_LOGIC_EN_ON       1'h1
`define OTFS_FAST_MODE_PULSE   1'h0
`define OTFS_FAST_MODE_DIGITAL 1'h1
`define OTFS_TERM_RESET        4'h0
`define OTFS_USER_COUNT        7

// ============================================================
// Timing
`define OTFS_CLK_HZ            32'h0131_2D00
`define OTFS_MS_PER_S          32'h0000_03E8
`define OTFS_INDEX_HOLD_MS     32'h0000_000A
`define OTFS_INDEX_HOLD_CYCLES \
    (`OTFS_INDEX_HOLD_MS * `OTFS_CLK_HZ / `OTFS_MS_PER_S)
`define OTFS_HOLD_CNT_W        18

`endif

// *** otfs_pkg.sv ***
`include "otfs_map.svh"

package otfs_pkg;

    typedef logic [5:0] otfs_sel_t;

    typedef enum logic [1:0] {
        OTFS_TERM_OC      = 2'h0,
        OTFS_TERM_FAST    = 2'h1,
        OTFS_TERM_RELAY_A = 2'h2,
        OTFS_TERM_RELAY_B = 2'h3
    } otfs_term_t;

    typedef enum logic {
        OTFS_HOLD_IDLE = 1'h0,
        OTFS_HOLD_BUSY = 1'h1
    } otfs_hold_st_t;

    typedef struct packed {
        logic       run_freq;
        logic       fwd_freq;
        logic       rev_freq;
        logic       jog_freq;
        logic       fault;
        logic       level_one;
        logic       level_two;
        logic       reached;
        logic       zero_speed;
        logic       upper;
        logic       lower;
        logic       ready;
        logic       preexc;
        logic       overload;
        logic       underload;
        logic       stage_done;
        logic       cycle_done;
        logic       dc_bus;
        logic       index_hold;
        logic       superpos;
        logic       torque_off;
        logic       pos_done;
        logic       zero_done;
        logic       div_done;
        logic       limit;
        logic       mode_sw_done;
        logic [6:0] user;
        logic       logic_en;
    } otfs_cond_t;

    typedef struct packed {
        logic modbus;
        logic fieldbus;
        logic ethernet;
        logic indeth;
    } otfs_vbit_t;

    typedef struct packed {
        otfs_hold_st_t               st;
        logic                        trig_q;
        logic [`OTFS_HOLD_CNT_W-1:0] cnt;
    } otfs_hold_state_t;

    typedef struct packed {
        logic [3:0] term;
        logic       fast;
    } otfs_top_state_t;

endpackage

// *** otfs_pulse_stretch.sv ***
`timescale 1ns/1ps
`include "otfs_map.svh"

module otfs_pulse_stretch #(
    parameter int unsigned HOLD_CYCLES = `OTFS_INDEX_HOLD_CYCLES
) (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic trig,
    output logic      active
);
    import otfs_pkg::*;

    localparam logic [`OTFS_HOLD_CNT_W-1:0] LOAD =
        `OTFS_HOLD_CNT_W'(HOLD_CYCLES - 1);

    otfs_hold_state_t s_q;
    otfs_hold_state_t s_d;

    // ========================================================
    // Retriggerable hold timer, restarted by each rising edge
    always_comb begin
        s_d        = s_q;
        s_d.trig_q = trig;
        case (s_q.st)
            OTFS_HOLD_IDLE: begin
                if (trig && !s_q.trig_q) begin
                    s_d.st  = OTFS_HOLD_BUSY;
                    s_d.cnt = LOAD;
                end
            end
            OTFS_HOLD_BUSY: begin
                if (trig && !s_q.trig_q) begin
                    s_d.cnt = LOAD;
                end else if (s_q.cnt == '0) begin
                    s_d.st = OTFS_HOLD_IDLE;
                end else begin
                    s_d.cnt = s_q.cnt - 1'b1;
                end
            end
            default: begin
                s_d.st = OTFS_HOLD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign active = (s_q.st == OTFS_HOLD_BUSY);

endmodule

// *** otfs_output_select.sv ***
`timescale 1ns/1ps
`include "otfs_map.svh"

// Functional notes
// - Four terminals, each with own selection code
// - Fast terminal: pulse output or plain digital
// - Shared codes drive terminals independently
// - Code 0 drives nothing
// - Codes 1-4: running states with frequency output
// - Code 5: drive fault present
// - Codes 6-8: level and reached flags
// - Code 9: output and reference frequency zero
// - Codes 10-11: upper and lower limit reached
// - Code 12: powered, unprotected, ready
// - Code 13: during pre-excitation
// - Codes 14-15: overload, underload pre-alarm
// - Codes 16-17: sequencer stage, cycle done
// - Codes 23,24,25,34 copy virtual bits
// - Code 26: DC bus above undervoltage
// - Code 27: index pulse held 10 ms
// - Code 28: pulse superposition active
// - Code 29: torque-off fault present
// - Codes 30-32: positioning, zeroing, division done
// - Code 33: frequency being limited
// - Code 36: speed/position switch-over done
module otfs_output_select #(
    parameter int unsigned INDEX_HOLD_CYCLES = `OTFS_INDEX_HOLD_CYCLES
) (
    input  wire logic              CLK,
    input  wire logic              RESETN,
    input  wire otfs_pkg::otfs_sel_t SEL_OC,
    input  wire otfs_pkg::otfs_sel_t SEL_FAST_PULSE,
    input  wire otfs_pkg::otfs_sel_t SEL_RELAY_A,
    input  wire otfs_pkg::otfs_sel_t SEL_RELAY_B,
    input  wire logic              FAST_PULSE_MODE,
    input  wire logic              PULSE_GEN_IN,
    input  wire logic              LOGIC_ENABLE_SETTING,
    input  wire logic              RUNNING,
    input  wire logic              FORWARD,
    input  wire logic              REVERSE,
    input  wire logic              JOGGING,
    input  wire logic              FREQ_OUTPUT_ACTIVE,
    input  wire logic              DRIVE_FAULT,
    input  wire logic              FREQ_LEVEL_FLAG_ONE,
    input  wire logic              FREQ_LEVEL_FLAG_TWO,
    input  wire logic              FREQ_REACHED,
    input  wire logic              OUT_FREQ_ZERO,
    input  wire logic              REF_FREQ_ZERO,
    input  wire logic              UPPER_LIMIT_REACHED,
    input  wire logic              LOWER_LIMIT_REACHED,
    input  wire logic              MAIN_POWER_OK,
    input  wire logic              CONTROL_POWER_OK,
    input  wire logic              PROTECTION_ACTIVE,
    input  wire logic              READY_TO_RUN,
    input  wire logic              PRE_EXCITING,
    input  wire logic              OVERLOAD_PREALARM,
    input  wire logic              UNDERLOAD_PREALARM,
    input  wire logic              SEQ_STAGE_DONE,
    input  wire logic              SEQ_CYCLE_DONE,
    input  wire logic              DC_BUS_ABOVE_UV,
    input  wire logic              ENCODER_INDEX,
    input  wire logic              PULSE_SUPERPOS_ACTIVE,
    input  wire logic              TORQUE_OFF_FAULT,
    input  wire logic              POSITIONING_DONE,
    input  wire logic              SPINDLE_ZERO_DONE,
    input  wire logic              SPINDLE_DIV_DONE,
    input  wire logic              FREQ_LIMITING,
    input  wire logic              MODE_SWITCH_DONE,
    input  wire logic [3:0]        MODBUS_VBIT,
    input  wire logic [3:0]        FIELDBUS_VBIT,
    input  wire logic [3:0]        ETHERNET_VBIT,
    input  wire logic [3:0]        IND_ETHERNET_VBIT,
    input  wire logic              LOGIC_USER_OUT_ONE,
    input  wire logic              LOGIC_USER_OUT_TWO,
    input  wire logic              LOGIC_USER_OUT_PULSE,
    input  wire logic              LOGIC_USER_RELAY_ONE,
    input  wire logic              LOGIC_USER_RELAY_TWO,
    input  wire logic              LOGIC_USER_RELAY_THREE,
    input  wire logic              LOGIC_USER_RELAY_FOUR,
    output logic                   OC_OUT,
    output logic                   FAST_PULSE_OUT,
    output logic                   RELAY_OUT_A,
    output logic                   RELAY_OUT_B,
    output logic [3:0]             TERMINAL_STATE
);
    import otfs_pkg::*;

    otfs_top_state_t s_q;
    otfs_top_state_t s_d;
    otfs_cond_t      cond;
    otfs_sel_t       sel      [4];
    otfs_vbit_t      vbit     [4];
    logic            index_hold;

    // ========================================================
    // Condition decode for one terminal
    function automatic logic otfs_decode(
        input otfs_sel_t  code,
        input otfs_cond_t c,
        input otfs_vbit_t v
    );
        logic       hit;
        logic [5:0] ui;
        hit = 1'b0;
        ui  = code - `OTFS_SEL_USER_FIRST;
        case (code)
            `OTFS_SEL_NONE:          hit = 1'b0;
            `OTFS_SEL_RUN:           hit = c.run_freq;
            `OTFS_SEL_FWD:           hit = c.fwd_freq;
            `OTFS_SEL_REV:           hit = c.rev_freq;
            `OTFS_SEL_JOG:           hit = c.jog_freq;
            `OTFS_SEL_FAULT:         hit = c.fault;
            `OTFS_SEL_LEVEL_ONE:     hit = c.level_one;
            `OTFS_SEL_LEVEL_TWO:     hit = c.level_two;
            `OTFS_SEL_REACHED:       hit = c.reached;
            `OTFS_SEL_ZERO_SPEED:    hit = c.zero_speed;
            `OTFS_SEL_UPPER:         hit = c.upper;
            `OTFS_SEL_LOWER:         hit = c.lower;
            `OTFS_SEL_READY:         hit = c.ready;
            `OTFS_SEL_PREEXC:        hit = c.preexc;
            `OTFS_SEL_OVERLOAD:      hit = c.overload;
            `OTFS_SEL_UNDERLOAD:     hit = c.underload;
            `OTFS_SEL_STAGE_DONE:    hit = c.stage_done;
            `OTFS_SEL_CYCLE_DONE:    hit = c.cycle_done;
            `OTFS_SEL_VBIT_MODBUS:   hit = v.modbus;
            `OTFS_SEL_VBIT_FIELDBUS: hit = v.fieldbus;
            `OTFS_SEL_VBIT_ETHERNET: hit = v.ethernet;
            `OTFS_SEL_VBIT_INDETH:   hit = v.indeth;
            `OTFS_SEL_DC_BUS:        hit = c.dc_bus;
            `OTFS_SEL_INDEX:         hit = c.index_hold;
            `OTFS_SEL_SUPERPOS:      hit = c.superpos;
            `OTFS_SEL_TORQUE_OFF:    hit = c.torque_off;
            `OTFS_SEL_POS_DONE:      hit = c.pos_done;
            `OTFS_SEL_ZERO_DONE:     hit = c.zero_done;
            `OTFS_SEL_DIV_DONE:      hit = c.div_done;
            `OTFS_SEL_LIMIT:         hit = c.limit;
            `OTFS_SEL_MODE_SW_DONE:  hit = c.mode_sw_done;
            default: begin
                if (code >= `OTFS_SEL_USER_FIRST &&
                    code <= `OTFS_SEL_USER_LAST) begin
                    // Routed only while the logic engine is enabled
                    hit = (c.logic_en == `OTFS_LOGIC_EN_ON) &&
                          c.user[ui[2:0]];
                end else begin
                    hit = 1'b0;
                end
            end
        endcase
        return hit;
    endfunction

    // ========================================================
    // Index pulse hold timer
    otfs_pulse_stretch #(
        .HOLD_CYCLES (INDEX_HOLD_CYCLES)
    ) u_index_hold (
        .clk    (CLK),
        .resetn (RESETN),
        .trig   (ENCODER_INDEX),
        .active (index_hold)
    );

    // ========================================================
    // Condition vector shared by all terminals
    always_comb begin
        cond              = '0;
        cond.run_freq     = RUNNING && FREQ_OUTPUT_ACTIVE;
        cond.fwd_freq     = RUNNING && FORWARD && FREQ_OUTPUT_ACTIVE;
        cond.rev_freq     = RUNNING && REVERSE && FREQ_OUTPUT_ACTIVE;
        cond.jog_freq     = RUNNING && JOGGING && FREQ_OUTPUT_ACTIVE;
        cond.fault        = DRIVE_FAULT;
        cond.level_one    = FREQ_LEVEL_FLAG_ONE;
        cond.level_two    = FREQ_LEVEL_FLAG_TWO;
        cond.reached      = FREQ_REACHED;
        cond.zero_speed   = OUT_FREQ_ZERO && REF_FREQ_ZERO;
        cond.upper        = UPPER_LIMIT_REACHED;
        cond.lower        = LOWER_LIMIT_REACHED;
        cond.ready        = MAIN_POWER_OK && CONTROL_POWER_OK &&
                            !PROTECTION_ACTIVE && READY_TO_RUN;
        cond.preexc       = PRE_EXCITING;
        cond.overload     = OVERLOAD_PREALARM;
        cond.underload    = UNDERLOAD_PREALARM;
        cond.stage_done   = SEQ_STAGE_DONE;
        cond.cycle_done   = SEQ_CYCLE_DONE;
        cond.dc_bus       = DC_BUS_ABOVE_UV;
        cond.index_hold   = index_hold;
        cond.superpos     = PULSE_SUPERPOS_ACTIVE;
        cond.torque_off   = TORQUE_OFF_FAULT;
        cond.pos_done     = POSITIONING_DONE;
        cond.zero_done    = SPINDLE_ZERO_DONE;
        cond.div_done     = SPINDLE_DIV_DONE;
        cond.limit        = FREQ_LIMITING;
        cond.mode_sw_done = MODE_SWITCH_DONE;
        cond.user         = {LOGIC_USER_RELAY_FOUR,
                             LOGIC_USER_RELAY_THREE,
                             LOGIC_USER_RELAY_TWO,
                             LOGIC_USER_RELAY_ONE,
                             LOGIC_USER_OUT_PULSE,
                             LOGIC_USER_OUT_TWO,
                             LOGIC_USER_OUT_ONE};
        cond.logic_en     = LOGIC_ENABLE_SETTING;
    end

    // ========================================================
    // Per-terminal selection codes and virtual bits
    always_comb begin
        sel[OTFS_TERM_OC]      = SEL_OC;
        sel[OTFS_TERM_FAST]    = SEL_FAST_PULSE;
        sel[OTFS_TERM_RELAY_A] = SEL_RELAY_A;
        sel[OTFS_TERM_RELAY_B] = SEL_RELAY_B;
        for (int i = 0; i < 4; i++) begin
            vbit[i].modbus   = MODBUS_VBIT[i];
            vbit[i].fieldbus = FIELDBUS_VBIT[i];
            vbit[i].ethernet = ETHERNET_VBIT[i];
            vbit[i].indeth   = IND_ETHERNET_VBIT[i];
        end
    end

    // ========================================================
    // Next state
    always_comb begin
        s_d = s_q;
        // Each terminal decodes on its own, so shared codes coexist
        for (int i = 0; i < 4; i++) begin
            s_d.term[i] = otfs_decode(sel[i], cond, vbit[i]);
        end
        if (FAST_PULSE_MODE == `OTFS_FAST_MODE_DIGITAL) begin
            s_d.fast = s_d.term[OTFS_TERM_FAST];
        end else begin
            s_d.fast = PULSE_GEN_IN;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ========================================================
    // Outputs
    assign OC_OUT         = s_q.term[OTFS_TERM_OC];
    assign FAST_PULSE_OUT = s_q.fast;
    assign RELAY_OUT_A    = s_q.term[OTFS_TERM_RELAY_A];
    assign RELAY_OUT_B    = s_q.term[OTFS_TERM_RELAY_B];
    assign TERMINAL_STATE = s_q.term;

endmodule

// *** otfs_checker_assertions.sv ***
`timescale 1ns/1ps
`include "otfs_map.svh"

module otfs_checker #(
    parameter int unsigned INDEX_HOLD_CYCLES = 8
) (
    input wire logic                CLK,
    input wire logic                RESETN,
    input wire otfs_pkg::otfs_sel_t SEL_OC,
    input wire otfs_pkg::otfs_sel_t SEL_RELAY_A,
    input wire otfs_pkg::otfs_sel_t SEL_RELAY_B,
    input wire logic                FAST_PULSE_MODE,
    input wire logic                PULSE_GEN_IN,
    input wire logic                LOGIC_ENABLE_SETTING,
    input wire logic                DRIVE_FAULT,
    input wire logic                ENCODER_INDEX,
    input wire logic [3:0]          MODBUS_VBIT,
    input wire logic                OC_OUT,
    input wire logic                FAST_PULSE_OUT,
    input wire logic                RELAY_OUT_A,
    input wire logic                RELAY_OUT_B,
    input wire logic [3:0]          TERMINAL_STATE
);
    import otfs_pkg::*;

    // ============================================================
    // Length of a code 27 pulse on the open collector terminal
    logic                        sel27_q;
    logic [`OTFS_HOLD_CNT_W-1:0] hi_cnt_q;
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            sel27_q  <= 1'h0;
            hi_cnt_q <= '0;
        end else begin
            sel27_q  <= (SEL_OC == `OTFS_SEL_INDEX);
            hi_cnt_q <= (OC_OUT && sel27_q) ? hi_cnt_q + 1'b1 : '0;
        end
    end

    // ============================================================
    // Properties
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    sequence idx_rise;
        !ENCODER_INDEX ##1 (ENCODER_INDEX && SEL_OC == `OTFS_SEL_INDEX);
    endsequence
    sequence idx_fall;
        $fell(OC_OUT) && sel27_q && $past(sel27_q);
    endsequence

    chk_none_off: assert property (
        SEL_OC == `OTFS_SEL_NONE |=> !OC_OUT)
        else $error("code zero drove the terminal");
    chk_fault_relay: assert property (
        SEL_RELAY_A == `OTFS_SEL_FAULT |=> RELAY_OUT_A == $past(DRIVE_FAULT))
        else $error("fault code not shown on relay A");
    chk_state_mirror: assert property (
        {RELAY_OUT_B, RELAY_OUT_A, OC_OUT} ==
        {TERMINAL_STATE[3], TERMINAL_STATE[2], TERMINAL_STATE[0]})
        else $error("terminal state differs from outputs");
    chk_pulse_pass: assert property (
        !FAST_PULSE_MODE |=> FAST_PULSE_OUT == $past(PULSE_GEN_IN))
        else $error("pulse mode does not pass generator");
    chk_fast_digital: assert property (
        FAST_PULSE_MODE |=> FAST_PULSE_OUT == TERMINAL_STATE[1])
        else $error("digital mode does not show decoded value");
    chk_vbit_copy: assert property (
        SEL_RELAY_B == `OTFS_SEL_VBIT_MODBUS |=>
        RELAY_OUT_B == $past(MODBUS_VBIT[3]))
        else $error("virtual bit not copied");
    chk_user_gated: assert property (
        SEL_OC inside {[`OTFS_SEL_USER_FIRST:`OTFS_SEL_USER_LAST]} &&
        !LOGIC_ENABLE_SETTING |=> !OC_OUT)
        else $error("user output routed while disabled");
    chk_reserved_off: assert property (
        SEL_RELAY_B inside {[6'h12:6'h16], 6'h23, [6'h25:6'h28],
        [6'h30:6'h3F]} |=> !RELAY_OUT_B)
        else $error("reserved code drove relay B");
    chk_index_start: assert property (
        idx_rise ##1 (SEL_OC == `OTFS_SEL_INDEX) |=> OC_OUT)
        else $error("index pulse not shown");
    chk_index_len: assert property (
        idx_fall |-> hi_cnt_q == INDEX_HOLD_CYCLES)
        else $error("index pulse length wrong");
    chk_index_bound: assert property (
        hi_cnt_q <= INDEX_HOLD_CYCLES)
        else $error("index pulse too long");
endmodule

bind otfs_output_select otfs_checker #(
    .INDEX_HOLD_CYCLES(INDEX_HOLD_CYCLES)
) chk_i (
    .CLK(CLK), .RESETN(RESETN), .SEL_OC(SEL_OC),
    .SEL_RELAY_A(SEL_RELAY_A), .SEL_RELAY_B(SEL_RELAY_B),
    .FAST_PULSE_MODE(FAST_PULSE_MODE), .PULSE_GEN_IN(PULSE_GEN_IN),
    .LOGIC_ENABLE_SETTING(LOGIC_ENABLE_SETTING),
    .DRIVE_FAULT(DRIVE_FAULT), .ENCODER_INDEX(ENCODER_INDEX),
    .MODBUS_VBIT(MODBUS_VBIT), .OC_OUT(OC_OUT),
    .FAST_PULSE_OUT(FAST_PULSE_OUT), .RELAY_OUT_A(RELAY_OUT_A),
    .RELAY_OUT_B(RELAY_OUT_B), .TERMINAL_STATE(TERMINAL_STATE)
);

// *** otfs_field_wiring.sv ***
`timescale 1ns/1ps

module otfs_field_wiring (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic [3:0] drive,
    output logic [3:0]      level,
    output logic [7:0]      pulse_cnt
);
    // ============================================================
    // Contacts follow the drive; a counter tallies fast rising edges
    logic       fast_q;
    logic [7:0] cnt_q;
    assign level = drive;
    assign pulse_cnt = cnt_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fast_q <= 1'h0;
            cnt_q  <= 8'h00;
        end else begin
            fast_q <= drive[1];
            if (drive[1] && !fast_q) begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps

module testbench;
    import otfs_pkg::*;
    localparam int HOLD = 8;
    logic        clk;
    logic        rst_n;
    logic [63:0] f;
    logic [3:0]  vb [4];
    logic        en;
    logic        mode;
    logic        pgen;
    logic        idx;
    otfs_sel_t   sel [4];
    logic        oc, fp, ra, rb;
    logic [3:0]  ts;
    logic [3:0]  outv;
    logic [7:0]  pcnt;
    logic [7:0]  base;
    int          fails;
    int          total_checks;
    logic [63:0] pat [4] = '{64'hFFFF_FFFF_FFFF_FFFF, 64'h0000_0000_0000_0000,
                             64'h5555_AAAA_3C3C_C3C3, 64'hAAAA_5555_C3C3_3C3C};

    assign outv = {rb, ra, fp, oc};
    always #25 clk = ~clk;

    otfs_output_select #(.INDEX_HOLD_CYCLES(HOLD)) dut (
        .CLK(clk), .RESETN(rst_n), .SEL_OC(sel[0]),
        .SEL_FAST_PULSE(sel[1]), .SEL_RELAY_A(sel[2]),
        .SEL_RELAY_B(sel[3]), .FAST_PULSE_MODE(mode),
        .PULSE_GEN_IN(pgen), .LOGIC_ENABLE_SETTING(en),
        .RUNNING(f[1]), .FORWARD(f[2]), .REVERSE(f[3]), .JOGGING(f[4]),
        .FREQ_OUTPUT_ACTIVE(f[50]), .DRIVE_FAULT(f[5]),
        .FREQ_LEVEL_FLAG_ONE(f[6]), .FREQ_LEVEL_FLAG_TWO(f[7]),
        .FREQ_REACHED(f[8]), .OUT_FREQ_ZERO(f[9]), .REF_FREQ_ZERO(f[51]),
        .UPPER_LIMIT_REACHED(f[10]), .LOWER_LIMIT_REACHED(f[11]),
        .MAIN_POWER_OK(f[12]), .CONTROL_POWER_OK(f[52]),
        .PROTECTION_ACTIVE(f[53]), .READY_TO_RUN(f[54]),
        .PRE_EXCITING(f[13]), .OVERLOAD_PREALARM(f[14]),
        .UNDERLOAD_PREALARM(f[15]), .SEQ_STAGE_DONE(f[16]),
        .SEQ_CYCLE_DONE(f[17]), .DC_BUS_ABOVE_UV(f[26]),
        .ENCODER_INDEX(idx), .PULSE_SUPERPOS_ACTIVE(f[28]),
        .TORQUE_OFF_FAULT(f[29]), .POSITIONING_DONE(f[30]),
        .SPINDLE_ZERO_DONE(f[31]), .SPINDLE_DIV_DONE(f[32]),
        .FREQ_LIMITING(f[33]), .MODE_SWITCH_DONE(f[36]),
        .MODBUS_VBIT(vb[0]), .FIELDBUS_VBIT(vb[1]),
        .ETHERNET_VBIT(vb[2]), .IND_ETHERNET_VBIT(vb[3]),
        .LOGIC_USER_OUT_ONE(f[41]), .LOGIC_USER_OUT_TWO(f[42]),
        .LOGIC_USER_OUT_PULSE(f[43]), .LOGIC_USER_RELAY_ONE(f[44]),
        .LOGIC_USER_RELAY_TWO(f[45]), .LOGIC_USER_RELAY_THREE(f[46]),
        .LOGIC_USER_RELAY_FOUR(f[47]), .OC_OUT(oc), .FAST_PULSE_OUT(fp),
        .RELAY_OUT_A(ra), .RELAY_OUT_B(rb), .TERMINAL_STATE(ts)
    );

    otfs_field_wiring fw (
        .clk(clk), .resetn(rst_n), .drive(outv), .level(), .pulse_cnt(pcnt)
    );

    // ============================================================
    // Helpers
    task automatic step;
        @(posedge clk);
        #1;
    endtask

    task automatic check(input logic seen, input logic exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %b expected %b", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        if (fails == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Expected terminal level for a code, index timer idle
    function automatic logic ref_out(input int c, input int t);
        if (c >= 1 && c <= 4) return f[1] & f[50] & (c == 1 || f[c]);
        if (c == 9) return f[9] & f[51];
        if (c == 12) return f[12] & f[52] & !f[53] & f[54];
        if (c >= 23 && c <= 25) return vb[c-23][t];
        if (c == 34) return vb[3][t];
        if (c >= 41 && c <= 47) return en & f[c];
        if (c inside {[5:8], 10, 11, [13:17], 26, [28:33], 36}) return f[c];
        return 1'b0;
    endfunction

    // Every code on every terminal, shared and staggered
    task automatic sweep;
        for (int o = 0; o < 2; o++) begin
            for (int p = 0; p < 4; p++) begin
                for (int c = 0; c < 64; c++) begin
                    f = pat[p];
                    en = p[0];
                    for (int k = 0; k < 4; k++) begin
                        vb[k] = f[k*4 +: 4];
                        sel[k] = otfs_sel_t'(c + k * o);
                    end
                    step();
                    for (int t = 0; t < 4; t++) begin
                        check(outv[t], ref_out(int'(sel[t]), t));
                        check(ts[t], ref_out(int'(sel[t]), t));
                    end
                end
            end
        end
    endtask

    // ============================================================
    // Main sequence
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        f = '0;
        en = 1'b0;
        mode = 1'b1;
        pgen = 1'b0;
        idx = 1'b0;
        fails = 0;
        total_checks = 0;
        for (int k = 0; k < 4; k++) begin
            vb[k] = 4'h0;
            sel[k] = 6'h00;
        end
        repeat (5) step();
        rst_n = 1'b1;
        sweep();
        mode = 1'b0;
        sel[1] = 6'h05;
        f = pat[0];
        step();
        base = pcnt;
        for (int i = 0; i < 8; i++) begin
            pgen = i[0];
            step();
            check(fp, pgen);
            check(ts[1], 1'b1);
        end
        pgen = 1'b0;
        repeat (2) step();
        check(pcnt == base + 8'h04, 1'b1);
        mode = 1'b1;
        for (int k = 0; k < 4; k++) begin
            sel[k] = 6'h1B;
        end
        step();
        idx = 1'b1;
        step();
        check(oc, 1'b0);
        for (int i = 0; i < HOLD; i++) begin
            step();
            check(oc, 1'b1);
            check(rb, 1'b1);
        end
        step();
        check(oc, 1'b0);
        idx = 1'b0;
        sel[2] = 6'h05;
        repeat (2) step();
        check(ra, 1'b1);
        rst_n = 1'b0;
        #1;
        check(|{outv, ts}, 1'b0);
        repeat (2) step();
        rst_n = 1'b1;
        step();
        check(ra, 1'b1);
        close_out();
    end

    initial begin
        #2000000;
        fails++;
        close_out();
    end
endmodule
